// File: logic/rftx_consts.vh
`ifndef RFTX_CONSTS_VH
`define RFTX_CONSTS_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the APB)
// ----------------------------------------------------------------------------
`define RFTX_ADDR_CTRL1 8'h04
`define RFTX_ADDR_CTRL4 8'h10
`define RFTX_ADDR_CTRL5 8'h14
`define RFTX_ADDR_CTRL6 8'h18
`define RFTX_ADDR_CTRL7 8'h1c
`define RFTX_ADDR_BUFWR 8'h20
`define RFTX_ADDR_STATUS 8'h24
`define RFTX_ADDR_CMD 8'h28

// ----------------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------------
`define RFTX_OPM_TX 3'h1
`define RFTX_C1_IRQ_LSB 3
`define RFTX_C1_PAT_BIT 5
`define RFTX_C1_TRN_BIT 6
`define RFTX_C4_MOD_BIT 0
`define RFTX_BUF_N_LSB 8
`define RFTX_CMD_DELIRQ_BIT 0
`define RFTX_BUF_DEPTH 5'h10

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RFTX_CTRL_RST 8'h00
`define RFTX_THRESH_RST 5'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RFTX_CLK_NS 50
`define RFTX_DCLK_NS 500
`define RFTX_STARTUP_DCLK_X10 3315
`define RFTX_STARTUP_CYC ((`RFTX_STARTUP_DCLK_X10 * `RFTX_DCLK_NS + 10 * `RFTX_CLK_NS - 1) / (10 * `RFTX_CLK_NS))
`define RFTX_HALF_BASE_CYC 16'h000a

`endif

// File: logic/rftx_sequencer.v
// Operation
// - Control register 1 op-mode bits equal to 001 select transmit mode.
// - Start-up lasts 331.5 divided-clock periods with synthesizer on, then waits for lock.
// - Buffer accepts host loads during start-up and during active transmit.
// - Sending starts itself once N bytes are buffered and transmit is active, MSB first.
// - Pending-byte counter counts loads up, sent bytes down, and is readable.
// - Interrupt rises when the counter reaches the level chosen by two select bits.
// - Level choices are 1, 2, 4 or 12 bytes, or buffer empty.
// - Buffer write, control 1/4/5/6/7 write or delete command clears the interrupt.
// - Control 1/4/5/6/7 write in transmit mode clears buffer and counter.
// - Transparent select disables the buffer and sends the data input pin.
// - Pattern select sends buffered bits as NRZ: 1 high, 0 low.
// - Manchester: buffered 1 goes low to high, buffered 0 high to low.
// - Transparent: pin high gives high, pin low gives low, pattern ignored.
// - Modulation type comes from the select bit in control register 4.
// - Bit rate comes from rate-range bits and rate-divider bits.
`include "rftx_consts.vh"

module rftx_sequencer (
    input wire clk_i,
    input wire sys_rst_i,
    input wire ce_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire serial_in_tx_stream_pin_i,
    input wire pll_lock_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    output reg pll_en_o,
    output reg tx_active_o,
    output reg tx_data_o,
    output reg modulation_select_o,
    output reg irq_o
);

    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_STARTUP = 3'h2;
    localparam [2:0] ST_ACTIVE = 3'h4;

    reg [2:0] state;
    reg [11:0] su_cnt;
    reg [7:0] ctrl1;
    reg [7:0] ctrl4;
    reg [7:0] ctrl5;
    reg [7:0] ctrl6;
    reg [7:0] ctrl7;
    reg [4:0] thresh;
    reg [7:0] mem [0:15];
    reg [3:0] wr_ptr;
    reg [3:0] rd_ptr;
    reg [4:0] count;
    reg sending;
    reg shift_busy;
    reg [7:0] shifter;
    reg [2:0] bit_idx;
    reg half;
    reg [15:0] half_cnt;
    reg [31:0] next_rdata;
    reg next_err;
    reg [4:0] irq_lvl;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    wire acc = psel_i & penable_i & pready_o;
    wire wr = acc & pwrite_i;
    wire wr_c1 = wr & (paddr_i == `RFTX_ADDR_CTRL1);
    wire wr_c4 = wr & (paddr_i == `RFTX_ADDR_CTRL4);
    wire wr_c5 = wr & (paddr_i == `RFTX_ADDR_CTRL5);
    wire wr_c6 = wr & (paddr_i == `RFTX_ADDR_CTRL6);
    wire wr_c7 = wr & (paddr_i == `RFTX_ADDR_CTRL7);
    wire wr_buf = wr & (paddr_i == `RFTX_ADDR_BUFWR);
    wire wr_cmd = wr & (paddr_i == `RFTX_ADDR_CMD);
    wire cfg_wr = wr_c1 | wr_c4 | wr_c5 | wr_c6 | wr_c7;
    wire del_irq = wr_cmd & pwdata_i[`RFTX_CMD_DELIRQ_BIT];
    wire op_tx = (pwdata_i[2:0] == `RFTX_OPM_TX);
    wire [31:0] su_load = `RFTX_STARTUP_CYC - 1;

    // ------------------------------------------------------------------------
    // Buffer control
    // ------------------------------------------------------------------------
    wire in_tx = (state == ST_STARTUP) | (state == ST_ACTIVE);
    wire active = (state == ST_ACTIVE);
    wire trans = ctrl1[`RFTX_C1_TRN_BIT];
    wire pattern = ctrl1[`RFTX_C1_PAT_BIT];
    wire flush = cfg_wr & in_tx;
    wire load = wr_buf & in_tx & ~trans & (count != `RFTX_BUF_DEPTH) & ~flush;
    wire pop = active & ~trans & sending & ~shift_busy & (count != 5'h00) & ~flush;
    wire [4:0] next_count = flush ? 5'h00 : count + {4'h0, load} - {4'h0, pop};
    wire [15:0] half_len = (({10'h000, ctrl7[5:0]} + 16'h0001) << ctrl6[1:0]) * `RFTX_HALF_BASE_CYC;
    wire cur_bit = shifter[bit_idx];
    always @*
    begin
        case (ctrl1[`RFTX_C1_IRQ_LSB +: 2])
            2'h0: irq_lvl = 5'h01;
            2'h1: irq_lvl = 5'h02;
            2'h2: irq_lvl = 5'h04;
            default: irq_lvl = 5'h0c;
        endcase
    end

    // Counter reaching the chosen level, or draining to empty by transmission.
    wire irq_hit = ~flush & (next_count != count) & ((next_count == irq_lvl) | (pop & (next_count == 5'h00)));
    wire irq_clr = wr_buf | cfg_wr | del_irq;

    // ------------------------------------------------------------------------
    // Read data and error answer, prepared in the setup cycle
    // ------------------------------------------------------------------------
    always @*
    begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        case (paddr_i)
            `RFTX_ADDR_CTRL1: next_rdata = {24'h000000, ctrl1};
            `RFTX_ADDR_CTRL4: next_rdata = {24'h000000, ctrl4};
            `RFTX_ADDR_CTRL5: next_rdata = {24'h000000, ctrl5};
            `RFTX_ADDR_CTRL6: next_rdata = {24'h000000, ctrl6};
            `RFTX_ADDR_CTRL7: next_rdata = {24'h000000, ctrl7};
            `RFTX_ADDR_BUFWR: next_rdata = {19'h00000, thresh, 8'h00};
            `RFTX_ADDR_STATUS: next_rdata = {16'h0000, 3'h0, count, sending, shift_busy, irq_o, 2'h0, state};
            `RFTX_ADDR_CMD: next_rdata = 32'h00000000;
            default: next_err = 1'b1;
        endcase
    end

    // ------------------------------------------------------------------------
    // APB slave and registers
    // ------------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
            ctrl1 <= `RFTX_CTRL_RST;
            ctrl4 <= `RFTX_CTRL_RST;
            ctrl5 <= `RFTX_CTRL_RST;
            ctrl6 <= `RFTX_CTRL_RST;
            ctrl7 <= `RFTX_CTRL_RST;
            thresh <= `RFTX_THRESH_RST;
        end
        else if (ce_i)
        begin
            if (psel_i & ~penable_i & ~pready_o)
            begin
                pready_o <= 1'b1;
                pslverr_o <= next_err;
                prdata_o <= pwrite_i ? 32'h00000000 : next_rdata;
            end
            else
            begin
                pready_o <= 1'b0;
                pslverr_o <= 1'b0;
            end
            if (wr_c1)
                ctrl1 <= pwdata_i[7:0];
            if (wr_c4)
                ctrl4 <= pwdata_i[7:0];
            if (wr_c5)
                ctrl5 <= pwdata_i[7:0];
            if (wr_c6)
                ctrl6 <= pwdata_i[7:0];
            if (wr_c7)
                ctrl7 <= pwdata_i[7:0];
            if (wr_buf)
                thresh <= (pwdata_i[`RFTX_BUF_N_LSB +: 5] > `RFTX_BUF_DEPTH) ?
                    `RFTX_BUF_DEPTH : pwdata_i[`RFTX_BUF_N_LSB +: 5];
        end
    end

    // ------------------------------------------------------------------------
    // Mode sequencing
    // ------------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state <= ST_IDLE;
            su_cnt <= 12'h000;
        end
        else if (ce_i)
        begin
            case (state)
                ST_IDLE:
                begin
                    if (wr_c1 & op_tx)
                    begin
                        state <= ST_STARTUP;
                        su_cnt <= su_load[11:0];
                    end
                end
                ST_STARTUP:
                begin
                    if (wr_c1 & ~op_tx)
                        state <= ST_IDLE;
                    else if (su_cnt != 12'h000)
                        su_cnt <= su_cnt - 12'h001;
                    else if (pll_lock_i)
                        state <= ST_ACTIVE;
                end
                ST_ACTIVE:
                begin
                    if (wr_c1 & ~op_tx)
                        state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Byte buffer, counter and interrupt
    // ------------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (ce_i & load)
            mem[wr_ptr] <= pwdata_i[7:0];
    end

    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            wr_ptr <= 4'h0;
            rd_ptr <= 4'h0;
            count <= 5'h00;
            sending <= 1'b0;
            irq_o <= 1'b0;
        end
        else if (ce_i)
        begin
            count <= next_count;
            if (flush)
            begin
                wr_ptr <= 4'h0;
                rd_ptr <= 4'h0;
            end
            else
            begin
                if (load)
                    wr_ptr <= wr_ptr + 4'h1;
                if (pop)
                    rd_ptr <= rd_ptr + 4'h1;
            end
            // A level reached in the same cycle as a clear keeps the interrupt.
            if (irq_hit)
                irq_o <= 1'b1;
            else if (irq_clr)
                irq_o <= 1'b0;
            if (flush | ~active)
                sending <= 1'b0;
            else if (next_count >= thresh)
                sending <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Bit engine and modulation mapping
    // ------------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            shift_busy <= 1'b0;
            shifter <= 8'h00;
            bit_idx <= 3'h0;
            half <= 1'b0;
            half_cnt <= 16'h0000;
        end
        else if (ce_i)
        begin
            if (flush | ~active | trans)
                shift_busy <= 1'b0;
            else if (~shift_busy)
            begin
                if (pop)
                begin
                    shifter <= mem[rd_ptr];
                    shift_busy <= 1'b1;
                    bit_idx <= 3'h7;
                    half <= 1'b0;
                    half_cnt <= half_len - 16'h0001;
                end
            end
            else if (half_cnt != 16'h0000)
                half_cnt <= half_cnt - 16'h0001;
            else
            begin
                half_cnt <= half_len - 16'h0001;
                half <= ~half;
                if (half)
                begin
                    if (bit_idx == 3'h0)
                        shift_busy <= 1'b0;
                    else
                        bit_idx <= bit_idx - 3'h1;
                end
            end
        end
    end

    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            tx_data_o <= 1'b0;
            pll_en_o <= 1'b0;
            tx_active_o <= 1'b0;
            modulation_select_o <= 1'b0;
        end
        else if (ce_i)
        begin
            pll_en_o <= in_tx;
            tx_active_o <= active;
            modulation_select_o <= ctrl4[`RFTX_C4_MOD_BIT];
            if (~active)
                tx_data_o <= 1'b0;
            else if (trans)
                tx_data_o <= serial_in_tx_stream_pin_i;
            else if (~shift_busy)
                tx_data_o <= 1'b0;
            else if (pattern)
                tx_data_o <= cur_bit;
            else
                tx_data_o <= half ? cur_bit : ~cur_bit;
        end
    end

endmodule // rftx_sequencer

// File: bench/rftx_pll_model.sv
// ----------------------------------------------------------------------------
// Synthesizer stand-in
// ----------------------------------------------------------------------------
module rftx_pll_model (
    input wire clk_i,
    input wire pll_en_i,
    input wire [31:0] delay_i,
    output logic pll_lock_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial pll_lock_o = 1'b0;
    // Lock comes delay_i cycles after enable and is lost at once when disabled.
    always @(posedge clk_i)
    begin
        cnt <= pll_en_i ? cnt + 1 : 0;
        pll_lock_o <= pll_en_i && cnt >= int'(delay_i);
    end
endmodule // rftx_pll_model

// File: bench/rftx_monitor.sv
`include "rftx_consts.vh"

module rftx_monitor (
    input wire clk_i,
    input wire sys_rst_i,
    input wire ce_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire serial_in_tx_stream_pin_i,
    input wire pll_lock_i,
    input wire pready_o,
    input wire pslverr_o,
    input wire pll_en_o,
    input wire tx_active_o,
    input wire tx_data_o,
    input wire modulation_select_o,
    input wire irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SU_MIN = 3314;
    logic trn = 1'b0;
    int su = 0;
    wire commit = ce_i && psel_i && penable_i && pready_o && pwrite_i;
    // ------------------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------------------
    // Tracks the transparent select and the cycles spent in start-up.
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
            trn <= 1'b0;
        else if (commit && paddr_i == `RFTX_ADDR_CTRL1)
            trn <= pwdata_i[`RFTX_C1_TRN_BIT];
        su <= (pll_en_o && !tx_active_o) ? su + 1 : 0;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    chk_apb_answer: assert property (ce_i && psel_i && !penable_i |=> pready_o)
        else $error("no pready after setup");
    chk_apb_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    chk_err_pair: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    chk_pll_cover: assert property (tx_active_o |-> pll_en_o)
        else $error("active without synthesizer");
    chk_startup_len: assert property ($rose(tx_active_o) |-> su >= SU_MIN)
        else $error("start-up too short");
    chk_lock_gate: assert property ($rose(tx_active_o) |-> $past(pll_lock_i))
        else $error("active without lock");
    chk_mod_follow: assert property (commit && paddr_i == `RFTX_ADDR_CTRL4 |-> ##2
        modulation_select_o == $past(pwdata_i[`RFTX_C4_MOD_BIT], 2)) else $error("modulation select wrong");
    chk_irq_clear: assert property (commit && (paddr_i inside {`RFTX_ADDR_CTRL1, `RFTX_ADDR_CTRL4,
        `RFTX_ADDR_CTRL5, `RFTX_ADDR_CTRL6, `RFTX_ADDR_CTRL7} || paddr_i == `RFTX_ADDR_CMD && pwdata_i[0])
        |=> !irq_o) else $error("irq not cleared");
    chk_idle_low: assert property (!tx_active_o ##1 !tx_active_o |-> !tx_data_o)
        else $error("data level while not active");
    chk_transparent: assert property (tx_active_o && $past(tx_active_o) && trn && $past(ce_i)
        |-> tx_data_o == $past(serial_in_tx_stream_pin_i)) else $error("pin not passed through");
    cover property ($rose(tx_active_o));
    cover property ($rose(irq_o));
    cover property (pslverr_o);
endmodule // rftx_monitor

bind rftx_sequencer rftx_monitor rftx_monitor_inst (.clk_i, .sys_rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .serial_in_tx_stream_pin_i, .pll_lock_i, .pready_o, .pslverr_o, .pll_en_o, .tx_active_o,
    .tx_data_o, .modulation_select_o, .irq_o);

// File: bench/tb_top.sv
`include "rftx_consts.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, sys_rst_i = 1, ce_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic serial_in_tx_stream_pin_i = 0, pll_lock_i, err;
    logic [7:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, q;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, pll_en_o, tx_active_o, tx_data_o, modulation_select_o, irq_o;
    int miscompares = 0, n_compared = 0, lock_dly = 20, n;
    int lvl[4] = '{1, 2, 4, 12};
    longint t0;
    always #25 clk_i = ~clk_i;
    rftx_sequencer rftx_sequencer_inst (.clk_i, .sys_rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .serial_in_tx_stream_pin_i, .pll_lock_i, .prdata_o, .pready_o, .pslverr_o, .pll_en_o,
        .tx_active_o, .tx_data_o, .modulation_select_o, .irq_o);
    rftx_pll_model rftx_pll_model_inst (.clk_i, .pll_en_i(pll_en_o), .delay_i(lock_dly), .pll_lock_o(pll_lock_i));
    // ------------------------------------------------------------------------
    // Bus and line tasks
    // ------------------------------------------------------------------------
    task tick(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int w;
        w = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1)
        begin
            w++;
            @(posedge clk_i);
        end
        `CHK(w, 0)
        q = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(q & m, e)
    endtask
    task ld(input logic [7:0] b, input logic [4:0] thr);
        wr(`RFTX_ADDR_BUFWR, {19'h0, thr, b});
        tick(2);
    endtask
    task wait_act;
        while (tx_active_o !== 1'b1 && ($time - t0) < 250000)
            tick(1);
        `CHK(tx_active_o, 1'b1)
        n = int'(($time - t0) / 50);
    endtask
    // Locks onto the first rising level, then samples the middle of each half bit, or of each whole bit for NRZ.
    task rx_byte(input logic [7:0] b, input logic nrz, input int h);
        int w;
        w = 0;
        while (tx_data_o !== 1'b1 && w < 2000)
        begin
            w++;
            tick(1);
        end
        `CHK(w < 2000, 1'b1)
        tick(nrz ? h : h / 2);
        for (int k = 7; k >= 0; k--)
        begin
            if (!nrz && k < 7)
            begin
                `CHK(tx_data_o, ~b[k])
                tick(h);
            end
            `CHK(tx_data_o, b[k])
            tick(nrz ? 2 * h : h);
        end
    endtask
    task end_sim;
        $display("Compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial
    begin
        tick(6);
        sys_rst_i <= 1'b0;
        rdc(`RFTX_ADDR_STATUS, 32'hffffffff, 32'h1);
        rdc(8'h00, 32'hffffffff, 32'h0);
        `CHK(err, 1'b1)
        for (int lv = 0; lv < 4; lv++)
        begin
            wr(`RFTX_ADDR_CTRL1, 32'h0);
            wr(`RFTX_ADDR_CTRL1, {27'h0, lv[1:0], 3'b001});
            for (int i = 0; i < lvl[lv]; i++)
            begin
                `CHK(irq_o, 1'b0)
                ld(8'h55, 5'h10);
            end
            `CHK(irq_o, 1'b1)
        end
        wr(`RFTX_ADDR_CMD, 32'h1);
        tick(2);
        `CHK(irq_o, 1'b0)
        wr(`RFTX_ADDR_CTRL1, 32'h0);
        wr(`RFTX_ADDR_CTRL4, 32'h1);
        tick(2);
        `CHK(modulation_select_o, 1'b1)
        wr(`RFTX_ADDR_CTRL6, 32'h0);
        wr(`RFTX_ADDR_CTRL7, 32'h0);
        wr(`RFTX_ADDR_CTRL1, 32'h09);
        t0 = $time;
        ld(8'ha5, 5'h03);
        `CHK(irq_o, 1'b0)
        ld(8'h3c, 5'h03);
        `CHK(irq_o, 1'b1)
        rdc(`RFTX_ADDR_STATUS, 32'h1f07, 32'h0202);
        wait_act();
        `CHK(n >= 3315 && n <= 3322, 1'b1)
        tick(100);
        `CHK(tx_data_o, 1'b0)
        ld(8'h81, 5'h03);
        rx_byte(8'ha5, 1'b0, 10);
        wr(`RFTX_ADDR_CMD, 32'h1);
        tick(2);
        `CHK(irq_o, 1'b0)
        tick(600);
        `CHK(irq_o, 1'b1)
        rdc(`RFTX_ADDR_STATUS, 32'h1f07, 32'h0004);
        wr(`RFTX_ADDR_CTRL5, 32'h0d);
        ld(8'h11, 5'h14);
        rdc(`RFTX_ADDR_BUFWR, 32'h1f00, 32'h1000);
        rdc(`RFTX_ADDR_CTRL5, 32'hff, 32'h0d);
        rdc(`RFTX_ADDR_STATUS, 32'h1f00, 32'h0100);
        wr(`RFTX_ADDR_CTRL7, 32'h0);
        rdc(`RFTX_ADDR_STATUS, 32'h1f00, 32'h0);
        `CHK(irq_o, 1'b0)
        lock_dly = 4000;
        wr(`RFTX_ADDR_CTRL1, 32'h0);
        wr(`RFTX_ADDR_CTRL6, 32'h1);
        wr(`RFTX_ADDR_CTRL7, 32'h1);
        wr(`RFTX_ADDR_CTRL1, 32'h21);
        t0 = $time;
        ld(8'hc3, 5'h01);
        wait_act();
        `CHK(n >= 4000 && n <= 4010, 1'b1)
        rx_byte(8'hc3, 1'b1, 40);
        lock_dly = 20;
        wr(`RFTX_ADDR_CTRL1, 32'h0);
        wr(`RFTX_ADDR_CTRL1, 32'h61);
        t0 = $time;
        wait_act();
        ld(8'h77, 5'h00);
        rdc(`RFTX_ADDR_STATUS, 32'h1f00, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            serial_in_tx_stream_pin_i <= i[0];
            tick(3);
            `CHK(tx_data_o, i[0])
        end
        ce_i <= 1'b0;
        serial_in_tx_stream_pin_i <= 1'b0;
        tick(4);
        `CHK(tx_data_o, 1'b1)
        ce_i <= 1'b1;
        wr(`RFTX_ADDR_CTRL1, 32'h0);
        tick(2);
        `CHK(pll_en_o, 1'b0)
        end_sim();
    end
    initial
    begin
        tick(60000);
        miscompares++;
        end_sim();
    end
endmodule // tb_top
